// ==== core/txup_halfband.sv ====
// half-band interpolate-by-two stage, taps -1 0 9 16 9 0 -1 over 16
module txup_halfband #(
  parameter int W = 12
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic in_stb_i,
  input wire logic out_stb_i,
  input wire logic signed [W-1:0] in_i,
  output logic signed [W-1:0] out_o
);
  logic signed [W-1:0] x0, x1, x2, x3;
  logic signed [W+5:0] interp;
  logic signed [W+1:0] interp_s;
  logic signed [W-1:0] interp_sat;

  // ===========================================================
  // odd phase: midpoint estimate, even phase: stored sample
  assign interp = (W+6)'(9 * (W+6)'(x1) + 9 * (W+6)'(x2) - (W+6)'(x0) - (W+6)'(x3));
  assign interp_s = interp[W+5:4];
  assign interp_sat = (interp_s > (W+2)'(2**(W-1)-1)) ? W'(2**(W-1)-1) :
                      (interp_s < -(W+2)'(2**(W-1))) ? W'(-(2**(W-1))) : interp_s[W-1:0];

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      {x0, x1, x2, x3} <= '0;
      out_o <= '0;
    end else begin
      if (in_stb_i) begin
        {x0, x1, x2, x3} <= {in_i, x0, x1, x2};
      end
      if (out_stb_i) begin
        out_o <= in_stb_i ? x1 : interp_sat;
      end
    end
  end
endmodule // txup_halfband

// ==== core/txup_top.sv ====
// transmit data path: word assembly, interpolation and quadrature upconversion
module txup_top (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [txup_pkg::WORD_W-1:0] tx_word_in_i,
  input wire logic tx_symbol_marker_i,
  input wire logic tx_powerdown_n_i,
  input wire logic single_tone_i,
  input wire logic cic_by4_i,
  input wire logic [txup_pkg::FTW_W-1:0] tuning_word_i,
  output logic mclk_o,
  output logic pair_rate_o,
  output logic pair_ready_o,
  output logic tx_overrun_o,
  output logic [txup_pkg::COMP_W-1:0] fast_dac_sample_o
);
  import txup_pkg::*;

  // ===========================================================
  // pin synchronisers
  logic [WORD_W-1:0] word_m, word_s;
  logic mark_m, mark_s, pd_m, run;

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      {word_m, word_s, mark_m, mark_s, pd_m, run} <= '0;
    end else begin
      word_m <= tx_word_in_i;
      word_s <= word_m;
      mark_m <= tx_symbol_marker_i;
      mark_s <= mark_m;
      pd_m <= tx_powerdown_n_i;
      run <= pd_m;
    end
  end

  // ===========================================================
  // rate enables; the master clock is made here by division
  logic [2:0] div, ratio;
  logic [1:0] quad;
  logic mclk_en, iq_en, hb1_out, hb2_out;

  assign ratio = cic_by4_i ? RATIO_4 : RATIO_3;
  // sample late in the period so the synchronised word has settled
  assign mclk_en = (div == ratio - 3'h1);
  assign iq_en = run && mclk_en && (quad == 2'h0);
  assign hb1_out = run && mclk_en && !quad[0];
  assign hb2_out = run && mclk_en;

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      div <= '0;
      quad <= '0;
      mclk_o <= 1'b0;
    end else begin
      div <= mclk_en ? 3'h0 : div + 3'h1;
      mclk_o <= mclk_en || (div < 3'h1);
      if (run && mclk_en) begin
        quad <= quad + 2'h1;
      end
    end
  end
  assign pair_rate_o = iq_en;

  // ===========================================================
  // word assembler
  logic [1:0] wcnt;
  logic [WORD_W-1:0] hi, prev_word;
  txup_comp_t i_hold;
  txup_pair_s in_pair;
  logic push, word_take;

  assign word_take = run && mclk_en;
  assign push = word_take && !mark_s && (wcnt == WCNT_LAST) && pair_ready_o;
  assign in_pair = '{i: i_hold, q: {hi, word_s}};

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      wcnt <= '0;
      hi <= '0;
      prev_word <= '0;
      i_hold <= '0;
      tx_overrun_o <= 1'b0;
    end else if (!run) begin
      wcnt <= '0;
    end else if (word_take) begin
      wcnt <= mark_s ? WCNT_AFTER_MARK : wcnt + 2'h1;
      // last word taken, kept so the assembly check does not lean on hi
      prev_word <= word_s;
      if (mark_s || !wcnt[0]) begin
        hi <= word_s;
      end
      if (!mark_s && wcnt == 2'h1) begin
        i_hold <= {hi, word_s};
      end
      if (!mark_s && wcnt == WCNT_LAST && !pair_ready_o) begin
        tx_overrun_o <= 1'b1;
      end
    end
  end

  // ===========================================================
  // two-entry pair buffer
  txup_pair_s buf0, buf1;
  logic [1:0] fill;
  logic pop;
  txup_pair_s head;

  assign pair_ready_o = (fill != 2'h2);
  assign pop = iq_en && (fill != 2'h0);
  assign head = (fill != 2'h0) ? buf0 : '0;

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      fill <= '0;
      buf0 <= '0;
      buf1 <= '0;
    end else begin
      if (pop) begin
        buf0 <= (fill == 2'h2) ? buf1 : in_pair;
      end else if (push && fill == 2'h0) begin
        buf0 <= in_pair;
      end
      if (push && ((fill == 2'h1 && !pop) || (fill == 2'h2))) begin
        buf1 <= in_pair;
      end
      fill <= fill + {1'b0, push} - {1'b0, pop};
    end
  end

  // ===========================================================
  // half-band cascade, signed samples throughout
  txup_comp_t hb1_i, hb1_q, hb2_i, hb2_q;

  txup_halfband #(.W(COMP_W)) u_hb1_i (.clock_i(clock_i), .rstn_i(rstn_i), .in_stb_i(iq_en),
    .out_stb_i(hb1_out), .in_i(head.i), .out_o(hb1_i));
  txup_halfband #(.W(COMP_W)) u_hb1_q (.clock_i(clock_i), .rstn_i(rstn_i), .in_stb_i(iq_en),
    .out_stb_i(hb1_out), .in_i(head.q), .out_o(hb1_q));
  txup_halfband #(.W(COMP_W)) u_hb2_i (.clock_i(clock_i), .rstn_i(rstn_i), .in_stb_i(hb1_out),
    .out_stb_i(hb2_out), .in_i(hb1_i), .out_o(hb2_i));
  txup_halfband #(.W(COMP_W)) u_hb2_q (.clock_i(clock_i), .rstn_i(rstn_i), .in_stb_i(hb1_out),
    .out_stb_i(hb2_out), .in_i(hb1_q), .out_o(hb2_q));

  // ===========================================================
  // two-stage integrator-comb interpolator, held in reset after power-down
  logic [6:0] hold;
  logic cic_rst;
  logic signed [CIC_W-1:0] ci_d, ci_c, cq_d, cq_c, ii1, ii2, iq1, iq2;
  logic signed [CIC_W-1:0] ci_n, cq_n, ci_in, cq_in;
  logic signed [CIC_W+6:0] si, sq;
  txup_comp_t cic_i, cic_q;

  assign cic_rst = !run || (hold != 7'h0);
  assign ci_n = CIC_W'(hb2_i) - ci_d;
  assign cq_n = CIC_W'(hb2_q) - cq_d;
  assign ci_in = hb2_out ? ci_n - ci_c : '0;
  assign cq_in = hb2_out ? cq_n - cq_c : '0;
  // the gain product is an int; cut it back to the scaler width on purpose
  assign si = cic_by4_i ? (CIC_W+7)'(ii2 >>> 2) :
              (CIC_W+7)'(((CIC_W+7)'(ii2) * DIV3_MUL) >>> DIV3_SHIFT);
  assign sq = cic_by4_i ? (CIC_W+7)'(iq2 >>> 2) :
              (CIC_W+7)'(((CIC_W+7)'(iq2) * DIV3_MUL) >>> DIV3_SHIFT);
  assign cic_i = si[COMP_W-1:0];
  assign cic_q = sq[COMP_W-1:0];

  always_ff @(posedge clock_i) begin
    if (!rstn_i || !run) begin
      hold <= CIC_HOLD_MCLK;
    end else if (mclk_en && hold != 7'h0) begin
      hold <= hold - 7'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i || cic_rst) begin
      {ci_d, ci_c, cq_d, cq_c, ii1, ii2, iq1, iq2} <= '0;
    end else begin
      if (hb2_out) begin
        ci_d <= CIC_W'(hb2_i);
        cq_d <= CIC_W'(hb2_q);
        ci_c <= ci_n;
        cq_c <= cq_n;
      end
      ii1 <= ii1 + ci_in;
      ii2 <= ii2 + ii1;
      iq1 <= iq1 + cq_in;
      iq2 <= iq2 + iq1;
    end
  end

  // ===========================================================
  // carrier generator and quadrature modulator
  logic [FTW_W-1:0] phase;
  txup_comp_t sin_v, cos_v;
  logic signed [2*COMP_W:0] mix;
  logic signed [COMP_W+1:0] mix_s;
  txup_comp_t mix_sat, next_sample;

  assign sin_v = txup_sin(phase[FTW_W-1 -: PHASE_W]);
  assign cos_v = txup_sin(phase[FTW_W-1 -: PHASE_W] + PHASE_W'(16));
  // widen before multiplying so the full product is kept
  assign mix = (2*COMP_W+1)'(cic_i) * (2*COMP_W+1)'(cos_v) -
               (2*COMP_W+1)'(cic_q) * (2*COMP_W+1)'(sin_v);
  assign mix_s = mix[SIN_SHIFT+COMP_W+1:SIN_SHIFT];
  assign mix_sat = (mix_s > 14'sh07FF) ? 12'sh7FF : (mix_s < -14'sh0800) ? 12'sh800 : mix_s[11:0];
  assign next_sample = single_tone_i ? cos_v : mix_sat;

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      phase <= '0;
      fast_dac_sample_o <= '0;
    end else begin
      phase <= phase + tuning_word_i;
      fast_dac_sample_o <= next_sample;
    end
  end

  // ===========================================================
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  sequence s_pd_release;
    !run ##1 run;
  endsequence
  sequence s_mark_taken;
    word_take && mark_s;
  endsequence

  property p_cic_hold;
    s_pd_release |-> (hold == CIC_HOLD_MCLK) && cic_rst;
  endproperty
  a_cic_hold: assert property (p_cic_hold) else $error("cic hold not loaded");

  property p_mark_align;
    s_mark_taken |=> (wcnt == WCNT_AFTER_MARK) && (hi == $past(word_s));
  endproperty
  a_mark_align: assert property (p_mark_align) else $error("marker not aligned");

  property p_pair_rate;
    push |-> mclk_en && (wcnt == WCNT_LAST) ##1 !push [*2];
  endproperty
  a_pair_rate: assert property (p_pair_rate) else $error("pair emitted off beat");

  property p_concat;
    push |-> (in_pair.q == {prev_word, word_s}) && (in_pair.i == i_hold);
  endproperty
  a_concat: assert property (p_concat) else $error("bad component assembly");

  property p_phase_step;
    ##1 phase == $past(phase) + $past(tuning_word_i);
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("carrier phase step wrong");

  property p_single_tone;
    single_tone_i |=> fast_dac_sample_o == $past(cos_v);
  endproperty
  a_single_tone: assert property (p_single_tone) else $error("tone not raw carrier");

  property p_iq_beat;
    iq_en |=> mclk_o && (quad == 2'h1);
  endproperty
  a_iq_beat: assert property (p_iq_beat) else $error("rate enables misaligned");

  property p_no_overfill;
    (fill == 2'h2) |-> !push ##1 (fill != 2'h3);
  endproperty
  a_no_overfill: assert property (p_no_overfill) else $error("pair buffer overfilled");

  property p_pd_stops;
    !run |-> !iq_en && !hb2_out ##1 (ii1 == '0);
  endproperty
  a_pd_stops: assert property (p_pd_stops) else $error("path ran in power-down");
endmodule // txup_top

// ==== inc/txup_pkg.sv ====
// constants and types shared by the transmit upconverter
// Contract
// - a high symbol marker starts a symbol and the word assembly aligns to it.
// - two consecutive 6-bit words form one 12-bit symbol component.
// - alternate components are in-phase then quadrature parts of one symbol.
// - components are signed twos complement values.
// - one I/Q pair is emitted per four word reads, at a quarter of the master rate.
// - two cascaded half-band stages raise the I and Q rate by four.
// - the half-band stages low-pass filter the upsampling images.
// - an integrator-comb interpolator raises the rate further by three or four.
// - a carrier generator on the system clock makes a carrier set by a tuning value.
// - I and Q are multiplied by carriers 90 degrees apart and the products summed.
// - the result leaves as 12-bit samples at the system clock rate.
// - the tuning word is 26 bits and sets frequency as a fraction of the system clock.
// - while power-down is low the path stops and the comb filter is reset, for 80 master clock cycles after.
// - single-tone mode outputs only the unmodulated carrier.
package txup_pkg;
  // ===========================================================
  // widths and counts
  localparam int WORD_W = 6;
  localparam int COMP_W = 12;
  localparam int FTW_W = 26;
  localparam int PHASE_W = 6;
  localparam int CIC_W = 20;
  localparam int WORDS_PER_PAIR = 4;
  localparam logic [6:0] CIC_HOLD_MCLK = 7'h50;
  localparam logic [1:0] WCNT_AFTER_MARK = 2'h1;
  localparam logic [1:0] WCNT_LAST = 2'h3;
  localparam logic [2:0] RATIO_3 = 3'h3;
  localparam logic [2:0] RATIO_4 = 3'h4;
  // divide by three is approximated by 21/64
  localparam int DIV3_MUL = 21;
  localparam int DIV3_SHIFT = 6;
  localparam int SIN_SHIFT = 11;

  typedef logic signed [COMP_W-1:0] txup_comp_t;

  typedef struct packed {
    txup_comp_t i;
    txup_comp_t q;
  } txup_pair_s;

  // quarter-wave sine, full scale 2047, index 0..16 of a quarter
  function automatic txup_comp_t txup_qsin(input logic [4:0] k);
    case (k)
      5'h00: txup_qsin = 12'sh000;
      5'h01: txup_qsin = 12'sh0C9;
      5'h02: txup_qsin = 12'sh18F;
      5'h03: txup_qsin = 12'sh252;
      5'h04: txup_qsin = 12'sh30F;
      5'h05: txup_qsin = 12'sh3C5;
      5'h06: txup_qsin = 12'sh471;
      5'h07: txup_qsin = 12'sh513;
      5'h08: txup_qsin = 12'sh5A7;
      5'h09: txup_qsin = 12'sh62E;
      5'h0A: txup_qsin = 12'sh6A6;
      5'h0B: txup_qsin = 12'sh70D;
      5'h0C: txup_qsin = 12'sh763;
      5'h0D: txup_qsin = 12'sh7A7;
      5'h0E: txup_qsin = 12'sh7D8;
      5'h0F: txup_qsin = 12'sh7F5;
      default: txup_qsin = 12'sh7FF;
    endcase
  endfunction

  function automatic txup_comp_t txup_sin(input logic [PHASE_W-1:0] p);
    logic [4:0] k;
    txup_comp_t m;
    k = p[4] ? (5'h10 - {1'b0, p[3:0]}) : {1'b0, p[3:0]};
    m = txup_qsin(k);
    txup_sin = p[5] ? -m : m;
  endfunction
endpackage

// ==== test/txup_host_model.sv ====
// host model driving the 6-bit word port of the transmit upconverter
module txup_host_model (
  input wire logic clock_i,
  input wire logic mclk_i,
  input wire logic slip_i,
  input wire txup_pkg::txup_pair_s pair_i,
  output logic [txup_pkg::WORD_W-1:0] word_o,
  output logic marker_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import txup_pkg::*;
  // ===========================================================
  // word sequencer
  logic mclk_d = 1'b0;
  logic pend = 1'b0;
  logic [1:0] cnt = 2'h0;
  logic [23:0] flat;
  initial begin
    word_o = '0;
    marker_o = 1'b0;
  end
  // words change just after the master clock rises and hold a whole period
  always @(negedge clock_i) begin
    if (slip_i) pend = 1'b1;
    if (mclk_i && !mclk_d) begin
      // take a whole pair at symbol start so a mid-symbol change never mixes two pairs
      if (cnt == 2'h0) begin
        flat = {pair_i.i, pair_i.q};
      end
      if (pend && cnt == 2'h0) begin
        // stray unmarked word, so the device has to realign on the marker
        word_o = 6'h2A;
        marker_o = 1'b0;
        pend = 1'b0;
      end else begin
        marker_o = (cnt == 2'h0);
        word_o = flat[23-6*cnt -: 6];
        cnt = cnt + 2'h1;
      end
    end
    mclk_d = mclk_i;
  end
endmodule // txup_host_model

// ==== test/txup_top_tb.sv ====
// self-checking bench of the transmit upconverter
module txup_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import txup_pkg::*;
  // ===========================================================
  // stimulus and wiring
  logic clock_i = 1'b0;
  logic rstn = 1'b0;
  logic pd = 1'b0;
  logic st = 1'b0;
  logic by4 = 1'b1;
  logic slip = 1'b0;
  logic [25:0] tw = '0;
  txup_pair_s pair = '0;
  logic [31:0] seed = 32'hE4E86EAC;
  wire logic [5:0] word;
  wire logic mark;
  logic mclk_o, pair_rate_o, pair_ready_o, tx_overrun_o;
  logic [11:0] s, s0, s1;
  int num_checks = 0;
  int miscompares = 0;
  int k;
  initial forever #5 clock_i = ~clock_i;
  txup_host_model host (.clock_i(clock_i), .mclk_i(mclk_o), .slip_i(slip), .pair_i(pair),
    .word_o(word), .marker_o(mark));
  txup_top DUT (.clock_i(clock_i), .rstn_i(rstn), .tx_word_in_i(word),
    .tx_symbol_marker_i(mark), .tx_powerdown_n_i(pd), .single_tone_i(st),
    .cic_by4_i(by4), .tuning_word_i(tw), .mclk_o(mclk_o), .pair_rate_o(pair_rate_o),
    .pair_ready_o(pair_ready_o), .tx_overrun_o(tx_overrun_o), .fast_dac_sample_o(s));
  // ===========================================================
  // helpers
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // settled output for a constant I, with zero carrier phase and a full scale of 2047
  function automatic logic [11:0] dc_out(input int i);
    return 12'((i * 2047) >>> SIN_SHIFT);
  endfunction
  task automatic check(input string n, input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic timeout();
    miscompares++;
    $display("BAD wait exp done seen timeout");
    stop_test();
  endtask
  task automatic rise(output int n);
    logic m;
    n = 0;
    do begin
      m = mclk_o;
      cyc(1);
      n++;
      if (n > 50) timeout();
    end while (!(mclk_o && !m));
  endtask
  task automatic pulses(input int n, output int c);
    c = 0;
    repeat (n) begin
      cyc(1);
      c += int'(pair_rate_o === 1'b1);
    end
  endtask
  task automatic reset_dut();
    rstn = 1'b0;
    pd = 1'b0;
    cyc(4);
    rstn = 1'b1;
  endtask
  task automatic slip_once();
    slip = 1'b1;
    cyc(1);
    slip = 1'b0;
  endtask
  // ===========================================================
  // scenarios
  initial begin
    cyc(3);
    check("rst_sample", s, 12'h000);
    check("rst_ready", {11'h0, pair_ready_o}, 12'h001);
    check("rst_ovr", {10'h0, tx_overrun_o, pair_rate_o}, 12'h000);
    cyc(1);
    rstn = 1'b1;
    // the first master clock pulse after reset is short, so measure a later period
    rise(k);
    rise(k);
    rise(k);
    check("period4", 12'(k), 12'h004);
    $display("test reset done");
    // carrier only; data on the port is random and must not show
    st = 1'b1;
    pd = 1'b1;
    cyc(10);
    repeat (8) begin
      seed = nxt(seed);
      pair = seed[23:0];
      check("tone0", s, 12'h7FF);
      cyc(1);
    end
    tw = 26'h2000000;
    cyc(4);
    s0 = s;
    repeat (8) begin
      cyc(1);
      check("tone_half", s, -s0);
      check("tone_lvl", {11'h0, s == 12'h7FF || s == 12'h801}, 12'h001);
      s0 = s;
    end
    tw = 26'h1000000;
    cyc(4);
    s0 = s;
    cyc(1);
    s1 = s;
    repeat (8) begin
      cyc(1);
      check("tone_qtr", s, -s0);
      s0 = s1;
      s1 = s;
    end
    $display("test tone done");
    // phase held at zero: sine is zero, so Q alone gives nothing
    st = 1'b0;
    tw = '0;
    reset_dut();
    pair = '{i: 12'h000, q: 12'h7C0};
    slip_once();
    pd = 1'b1;
    cyc(1200);
    repeat (16) begin
      check("q_only", s, 12'h000);
      cyc(1);
    end
    pulses(64, k);
    check("pairs4", 12'(k), 12'h004);
    check("no_ovr", {10'h0, tx_overrun_o, pair_ready_o}, 12'h001);
    $display("test quadrature done");
    // low word carries the sign bit if the two 6-bit words were swapped
    seed = nxt(seed);
    pair = '{i: 12'h020, q: seed[11:0]};
    slip_once();
    cyc(800);
    check("i_pos", {11'h0, !s[11] && s != 12'h000}, 12'h001);
    check("i_dc", s, dc_out(32));
    pair.i = 12'hFDF;
    slip_once();
    cyc(800);
    check("i_neg", {11'h0, s[11]}, 12'h001);
    check("i_dc_neg", s, dc_out(-33));
    $display("test assembly done");
    pd = 1'b0;
    cyc(40);
    check("pdown", s, 12'h000);
    pd = 1'b1;
    k = 0;
    while (s === 12'h000) begin
      cyc(1);
      k++;
      if (k > 2000) timeout();
    end
    // 80 master periods of 4 system clocks, minus the input synchroniser
    check("cic_hold", {11'h0, k >= 316 && k < 1000}, 12'h001);
    $display("test powerdown done");
    by4 = 1'b0;
    cyc(100);
    rise(k);
    rise(k);
    check("period3", 12'(k), 12'h003);
    pulses(48, k);
    check("pairs3", 12'(k), 12'h004);
    $display("test ratio done");
    stop_test();
  end
endmodule // txup_top_tb
